// ===== src/sbf_defs.svh
/*
 * Register offsets, field positions, reset values, bit masks and
 * AXI response codes for the slip buffer event flag block. Included by
 * the package and by the sbf_slip_flags module; holds definitions only.
 */
`ifndef SBF_DEFS_SVH
`define SBF_DEFS_SVH

// Register byte offsets on the AXI4-Lite bus
`define SBF_OFS_FLAGS 5'h00
`define SBF_OFS_ENABLES 5'h04
`define SBF_OFS_RXEN 5'h08
`define SBF_OFS_IRQ_STATUS 5'h0c
`define SBF_OFS_IRQ_MASK 5'h10

// Field positions, shared by flags and enables
`define SBF_BIT_RX_ANY_SLIP 0
`define SBF_BIT_RX_UNDERFLOW 1
`define SBF_BIT_RX_OVERFLOW 2
`define SBF_BIT_SYNC_SPECIAL 4
`define SBF_BIT_TX_ANY_SLIP 5
`define SBF_BIT_TX_UNDERFLOW 6
`define SBF_BIT_TX_OVERFLOW 7

// Reset values
`define SBF_RST_FLAGS 8'h00
`define SBF_RST_ENABLES 8'h00
`define SBF_RST_RXEN 8'h00
`define SBF_RST_IRQ_MASK 8'h00

// Valid bit masks
`define SBF_MASK_EVENTS 8'he7
`define SBF_MASK_ENABLES 8'he0
`define SBF_MASK_RXEN 8'h07

// AXI response codes
`define SBF_RESP_OKAY 2'b00
`define SBF_RESP_SLVERR 2'b10

`endif

// ===== src/sbf_pkg.sv
/*
 * Types for the slip buffer event flag block.
 * Assumes sbf_defs.svh is on the include path.
 */
package sbf_pkg;
    `include "sbf_defs.svh"

    typedef logic [7:0] sbf_byte_t;

    typedef enum logic [2:0] {
        SBF_W_IDLE = 3'b001,
        SBF_W_RESP = 3'b010,
        SBF_W_HOLD = 3'b100
    } sbf_wstate_t;
endpackage : sbf_pkg

// ===== src/sbf_event_sync.sv
/*
 * Synchroniser and rising edge detector for the four slip buffer
 * event strobes that come from outside the clock domain.
 * Assumes clk and arst_n of the register domain.
 */
`timescale 1ns/1ps
module sbf_event_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,                // Register clock
    input wire logic arst_n,             // Async reset, active low
    input wire logic [WIDTH-1:0] evIn,   // Raw event levels
    output logic [WIDTH-1:0] evPulse     // One-cycle pulse per rising edge
);
    import sbf_pkg::*;

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic [WIDTH-1:0] last;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_sync;
    logic [WIDTH-1:0] next_last;

    always_comb
    begin
        next_meta = evIn;
        next_sync = meta;
        next_last = sync;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta <= '0;
            sync <= '0;
            last <= '0;
        end
        else
        begin
            meta <= next_meta;
            sync <= next_sync;
            last <= next_last;
        end
    end

    assign evPulse = sync & ~last;
endmodule : sbf_event_sync

// ===== src/sbf_slip_flags.sv
/*
 * Slip buffer event flags, enables and interrupt logic of one framer
 * channel, with an AXI4-Lite register slave.
 * Assumes slip events arrive as levels that rise once per slip and
 * may come from another clock; a rising level is one slip.
 */
// Contract
// - Receive read on empty buffer repeats frame; sets receive underflow flag bit 1.
// - Receive flags record events since last read; clear on read; reset to 0.
// - Receive any-slip flag bit 0 sets on overflow or underflow.
// - Receive write on full buffer drops frame; sets receive any-slip flag.
// - Enable bit 7 gates transmit overflow interrupt; read/write; reset 0.
// - Enable bit 6 gates transmit underflow interrupt; read/write; reset 0.
// - Enable bit 5 gates transmit any-slip interrupt; read/write; reset 0.
// - Transmit read on empty buffer repeats frame; sets transmit flag.
// - Transmit write on full buffer deletes frame; sets transmit flag.
// - Status bit 2 is receive overflow flag; set by full write; clear on read.
// - Status bits 7,6,5 hold transmit overflow, underflow, any-slip; clear on read.
`timescale 1ns/1ps
`include "sbf_defs.svh"
module sbf_slip_flags (
    input wire logic clk,                  // 40 MHz register clock
    input wire logic arst_n,               // Async reset, active low
    input wire logic rxUnderflowEv,        // Receive read met empty buffer
    input wire logic rxOverflowEv,         // Receive write met full buffer
    input wire logic txUnderflowEv,        // Transmit read met empty buffer
    input wire logic txOverflowEv,         // Transmit write met full buffer
    input wire logic syncSpecial,          // Special framing lock level
    output logic slipIrq,                  // Slip interrupt request to host
    output logic blockIrq,                 // Masked event status interrupt
    input wire logic [4:0] s_axi_awaddr,   // Write address
    input wire logic s_axi_awvalid,        // Write address valid
    output logic s_axi_awready,            // Write address ready
    input wire logic [31:0] s_axi_wdata,   // Write data
    input wire logic [3:0] s_axi_wstrb,    // Write strobes
    input wire logic s_axi_wvalid,         // Write data valid
    output logic s_axi_wready,             // Write data ready
    output logic [1:0] s_axi_bresp,        // Write response
    output logic s_axi_bvalid,             // Write response valid
    input wire logic s_axi_bready,         // Write response ready
    input wire logic [4:0] s_axi_araddr,   // Read address
    input wire logic s_axi_arvalid,        // Read address valid
    output logic s_axi_arready,            // Read address ready
    output logic [31:0] s_axi_rdata,       // Read data
    output logic [1:0] s_axi_rresp,        // Read response
    output logic s_axi_rvalid,             // Read data valid
    input wire logic s_axi_rready          // Read data ready
);
    import sbf_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Event capture

    logic [3:0] evPulse;
    logic [1:0] syncMeta;
    logic syncLevel;
    logic rxUnd;
    logic rxOvf;
    logic txUnd;
    logic txOvf;

    sbf_event_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .evIn({txOverflowEv, txUnderflowEv, rxOverflowEv, rxUnderflowEv}),
        .evPulse(evPulse)
    );

    assign rxUnd = evPulse[0];
    assign rxOvf = evPulse[1];
    assign txUnd = evPulse[2];
    assign txOvf = evPulse[3];

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            syncMeta <= 2'h0;
        else
            syncMeta <= {syncMeta[0], syncSpecial};
    end
    assign syncLevel = syncMeta[1];

    // Event vector in flag layout
    function automatic sbf_byte_t event_vec(input logic ru, input logic ro,
                                           input logic tu, input logic to);
        sbf_byte_t v;
        v = 8'h00;
        v[`SBF_BIT_RX_UNDERFLOW] = ru;
        v[`SBF_BIT_RX_OVERFLOW] = ro;
        v[`SBF_BIT_RX_ANY_SLIP] = ru | ro;
        v[`SBF_BIT_TX_UNDERFLOW] = tu;
        v[`SBF_BIT_TX_OVERFLOW] = to;
        v[`SBF_BIT_TX_ANY_SLIP] = tu | to;
        return v;
    endfunction : event_vec

    sbf_byte_t events;
    assign events = event_vec(rxUnd, rxOvf, txUnd, txOvf);

    ////////////////////////////////////////////////////////////////////
    // Register state

    sbf_byte_t flags;
    sbf_byte_t enables;
    sbf_byte_t rxEnables;
    sbf_byte_t irqStatus;
    sbf_byte_t irqMask;
    sbf_byte_t next_flags;
    sbf_byte_t next_enables;
    sbf_byte_t next_rxEnables;
    sbf_byte_t next_irqStatus;
    sbf_byte_t next_irqMask;

    ////////////////////////////////////////////////////////////////////
    // Write channel

    sbf_wstate_t wState;
    sbf_wstate_t next_wState;
    logic awHeld;
    logic wHeld;
    logic next_awHeld;
    logic next_wHeld;
    logic [4:0] awAddr;
    logic [4:0] next_awAddr;
    logic [31:0] wData;
    logic [31:0] next_wData;
    logic [3:0] wStrb;
    logic [3:0] next_wStrb;
    logic [1:0] bresp;
    logic [1:0] next_bresp;
    logic wrDo;
    logic [4:0] wrAddr;
    logic [31:0] wrData;
    logic wrLane0;

    function automatic logic addr_ok(input logic [4:0] a);
        return a[1:0] == 2'b00 && (a[4:2] <= 3'h4);
    endfunction : addr_ok

    assign s_axi_awready = (wState == SBF_W_IDLE) && !awHeld;
    assign s_axi_wready = (wState == SBF_W_IDLE) && !wHeld;
    assign s_axi_bvalid = (wState == SBF_W_RESP);
    assign s_axi_bresp = bresp;

    always_comb
    begin
        next_wState = wState;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_wStrb = wStrb;
        next_bresp = bresp;
        wrDo = 1'b0;
        wrAddr = awAddr;
        wrData = wData;
        wrLane0 = wStrb[0];
        case (wState)
            SBF_W_IDLE:
            begin
                if (s_axi_awvalid && !awHeld)
                begin
                    next_awHeld = 1'b1;
                    next_awAddr = s_axi_awaddr;
                    wrAddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && !wHeld)
                begin
                    next_wHeld = 1'b1;
                    next_wData = s_axi_wdata;
                    next_wStrb = s_axi_wstrb;
                    wrData = s_axi_wdata;
                    wrLane0 = s_axi_wstrb[0];
                end
                if (next_awHeld && next_wHeld)
                begin
                    wrDo = 1'b1;
                    next_awHeld = 1'b0;
                    next_wHeld = 1'b0;
                    next_bresp = addr_ok(wrAddr) ? `SBF_RESP_OKAY : `SBF_RESP_SLVERR;
                    next_wState = SBF_W_RESP;
                end
            end
            SBF_W_RESP:
            begin
                if (s_axi_bready)
                    next_wState = SBF_W_IDLE;
            end
            default:
                next_wState = SBF_W_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wState <= SBF_W_IDLE;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= 5'h00;
            wData <= 32'h0000_0000;
            wStrb <= 4'h0;
            bresp <= `SBF_RESP_OKAY;
        end
        else
        begin
            wState <= next_wState;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            wStrb <= next_wStrb;
            bresp <= next_bresp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Read channel

    logic rvalid;
    logic next_rvalid;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic [1:0] rresp;
    logic [1:0] next_rresp;
    logic rdTake;
    logic flagsRead;

    assign s_axi_arready = !rvalid;
    assign s_axi_rvalid = rvalid;
    assign s_axi_rdata = rdata;
    assign s_axi_rresp = rresp;
    assign rdTake = s_axi_arvalid && !rvalid;
    assign flagsRead = rdTake && (s_axi_araddr == 5'(`SBF_OFS_FLAGS));

    always_comb
    begin
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (rvalid && s_axi_rready)
            next_rvalid = 1'b0;
        if (rdTake)
        begin
            next_rvalid = 1'b1;
            next_rresp = addr_ok(s_axi_araddr) ? `SBF_RESP_OKAY : `SBF_RESP_SLVERR;
            case (s_axi_araddr)
                5'(`SBF_OFS_FLAGS):
                    next_rdata = {24'h0, flags | (8'(syncLevel) << `SBF_BIT_SYNC_SPECIAL)};
                5'(`SBF_OFS_ENABLES):
                    next_rdata = {24'h0, enables};
                5'(`SBF_OFS_RXEN):
                    next_rdata = {24'h0, rxEnables};
                5'(`SBF_OFS_IRQ_STATUS):
                    next_rdata = {24'h0, irqStatus};
                5'(`SBF_OFS_IRQ_MASK):
                    next_rdata = {24'h0, irqMask};
                default:
                    next_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `SBF_RESP_OKAY;
        end
        else
        begin
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flags, enables and interrupts

    always_comb
    begin
        next_flags = flags;
        next_enables = enables;
        next_rxEnables = rxEnables;
        next_irqStatus = irqStatus;
        next_irqMask = irqMask;
        if (flagsRead)
            next_flags = `SBF_RST_FLAGS;
        next_flags = next_flags | events;
        if (wrDo && wrLane0)
        begin
            case (wrAddr)
                5'(`SBF_OFS_ENABLES):
                    next_enables = wrData[7:0] & `SBF_MASK_ENABLES;
                5'(`SBF_OFS_RXEN):
                    next_rxEnables = wrData[7:0] & `SBF_MASK_RXEN;
                5'(`SBF_OFS_IRQ_STATUS):
                    next_irqStatus = irqStatus & ~wrData[7:0];
                5'(`SBF_OFS_IRQ_MASK):
                    next_irqMask = wrData[7:0] & `SBF_MASK_EVENTS;
                default:
                    next_irqMask = irqMask;
            endcase
        end
        next_irqStatus = next_irqStatus | events;
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            flags <= `SBF_RST_FLAGS;
            enables <= `SBF_RST_ENABLES;
            rxEnables <= `SBF_RST_RXEN;
            irqStatus <= `SBF_RST_FLAGS;
            irqMask <= `SBF_RST_IRQ_MASK;
        end
        else
        begin
            flags <= next_flags;
            enables <= next_enables;
            rxEnables <= next_rxEnables;
            irqStatus <= next_irqStatus;
            irqMask <= next_irqMask;
        end
    end

    // Receive enables live in the next register but gate here too
    assign slipIrq = |(flags & (enables | rxEnables));
    assign blockIrq = |(irqStatus & irqMask);
endmodule : sbf_slip_flags

// ===== testbench/sbf_slip_flags_asserts.sv
/*
 * Concurrent checks on the ports of the slip buffer flag block.
 * Assumes it is bound into sbf_slip_flags with one clock domain.
 */
`timescale 1ns/1ps
module sbf_slip_flags_asserts (
    input wire logic clk, // Clock
    input wire logic arst_n, // Reset, active low
    input wire logic rxUnderflowEv, // Event
    input wire logic rxOverflowEv, // Event
    input wire logic txUnderflowEv, // Event
    input wire logic txOverflowEv, // Event
    input wire logic slipIrq, // Interrupt
    input wire logic s_axi_awvalid, // Bus
    input wire logic s_axi_awready, // Bus
    input wire logic s_axi_wvalid, // Bus
    input wire logic s_axi_wready, // Bus
    input wire logic [1:0] s_axi_bresp, // Bus
    input wire logic s_axi_bvalid, // Bus
    input wire logic s_axi_bready, // Bus
    input wire logic [4:0] s_axi_araddr, // Bus
    input wire logic s_axi_arvalid, // Bus
    input wire logic s_axi_arready, // Bus
    input wire logic [31:0] s_axi_rdata, // Bus
    input wire logic [1:0] s_axi_rresp, // Bus
    input wire logic s_axi_rvalid, // Bus
    input wire logic s_axi_rready // Bus
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic [3:0] evNow;
    logic [3:0] evLast;
    logic [2:0] quiet;
    logic [2:0] next_quiet;
    assign evNow = {rxUnderflowEv, rxOverflowEv, txUnderflowEv, txOverflowEv};
    // Cycles since any event pin moved
    always_comb
    begin
        next_quiet = quiet;
        if (evNow != evLast)
            next_quiet = 3'h0;
        else if (quiet != 3'h7)
            next_quiet = quiet + 3'h1;
    end
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            quiet <= 3'h0;
            evLast <= 4'h0;
        end
        else
        begin
            quiet <= next_quiet;
            evLast <= evNow;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_clear_on_read;
        s_axi_arvalid && s_axi_arready && s_axi_araddr == 5'h00 && quiet >= 3'h5
            |=> !slipIrq;
    endproperty
    a_clear_on_read: assert property (p_clear_on_read) else $error("irq after read");
    property p_rdata_upper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_rdata_upper: assert property (p_rdata_upper) else $error("upper bits set");
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_rhold: assert property (p_rhold) else $error("read data moved");
    property p_rafter;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##0 !s_axi_arready;
    endproperty
    a_rafter: assert property (p_rafter) else $error("no read answer");
    property p_bafter;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
    endproperty
    a_bafter: assert property (p_bafter) else $error("no write answer");
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bhold: assert property (p_bhold) else $error("write response moved");
    property p_brefuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    a_brefuse: assert property (p_brefuse) else $error("write taken while busy");
    property p_unmapped;
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h10 |=> s_axi_rresp == 2'b10;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read okay");
endmodule : sbf_slip_flags_asserts

bind sbf_slip_flags sbf_slip_flags_asserts u_chk (.clk, .arst_n, .rxUnderflowEv, .rxOverflowEv,
    .txUnderflowEv, .txOverflowEv, .slipIrq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// ===== testbench/sbf_slip_flags_tb_top.sv
/*
 * Self-checking bench for the slip buffer flag block.
 * Assumes the design and its package are compiled first.
 */
`timescale 1ns/1ps
module sbf_slip_flags_tb_top;
    import sbf_pkg::*;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] ev = 4'h0;
    logic syncSpecial = 1'b0;
    logic slipIrq, blockIrq, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [4:0] s_axi_awaddr = 5'h0;
    logic [4:0] s_axi_araddr = 5'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    int errTotal = 0;
    int compares = 0;
    sbf_slip_flags DUT (.clk, .arst_n, .rxUnderflowEv(ev[0]), .rxOverflowEv(ev[1]),
        .txUnderflowEv(ev[2]), .txOverflowEv(ev[3]), .syncSpecial, .slipIrq, .blockIrq,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errTotal++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw && w))
        begin
            @(posedge clk);
            if (!aw && s_axi_awready === 1'b1)
            begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1)
            begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
    endtask : wr
    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input logic [1:0] er);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, {24'h0, exp});
        chk({30'h0, s_axi_rresp}, {30'h0, er});
    endtask : rd
    // One slip on event pin i, then time for it to land
    task automatic fire(input int i);
        @(posedge clk);
        ev[i] <= 1'b1;
        repeat (2) @(posedge clk);
        ev[i] <= 1'b0;
        repeat (5) @(posedge clk);
    endtask : fire
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] expF [4] = '{8'h03, 8'h05, 8'h60, 8'ha0};
    task automatic test_regs;
        rd(5'h00, 8'h00, 2'b00);
        rd(5'h04, 8'h00, 2'b00);
        chk({31'h0, slipIrq}, 32'h0);
        wr(5'h04, 8'hff, 2'b00);
        rd(5'h04, 8'he0, 2'b00);
        wr(5'h04, 8'h00, 2'b00);
        rd(5'h04, 8'h00, 2'b00);
        rd(5'h14, 8'h00, 2'b10);
        rd(5'h02, 8'h00, 2'b10);
        wr(5'h14, 8'hff, 2'b10);
        $display("test_regs done");
    endtask : test_regs
    task automatic test_events;
        for (int i = 0; i < 4; i++)
        begin
            fire(i);
            rd(5'h00, expF[i], 2'b00);
            rd(5'h00, 8'h00, 2'b00);
        end
        $display("test_events done");
    endtask : test_events
    task automatic test_gating;
        logic [7:0] en [4] = '{8'h80, 8'h40, 8'h20, 8'h40};
        int src [4] = '{3, 2, 3, 3};
        logic [31:0] irq [4] = '{32'h1, 32'h1, 32'h1, 32'h0};
        for (int i = 0; i < 4; i++)
        begin
            wr(5'h04, en[i], 2'b00);
            fire(src[i]);
            chk({31'h0, slipIrq}, irq[i]);
            rd(5'h00, expF[src[i]], 2'b00);
            chk({31'h0, slipIrq}, 32'h0);
        end
        wr(5'h04, 8'h00, 2'b00);
        wr(5'h08, 8'hff, 2'b00);
        rd(5'h08, 8'h07, 2'b00);
        fire(0);
        chk({31'h0, slipIrq}, 32'h1);
        rd(5'h00, 8'h03, 2'b00);
        wr(5'h08, 8'h00, 2'b00);
        $display("test_gating done");
    endtask : test_gating
    task automatic test_block;
        wr(5'h0c, 8'he7, 2'b00);
        fire(1);
        rd(5'h0c, 8'h05, 2'b00);
        chk({31'h0, blockIrq}, 32'h0);
        wr(5'h10, 8'h04, 2'b00);
        rd(5'h10, 8'h04, 2'b00);
        chk({31'h0, blockIrq}, 32'h1);
        wr(5'h0c, 8'h04, 2'b00);
        rd(5'h0c, 8'h01, 2'b00);
        chk({31'h0, blockIrq}, 32'h0);
        rd(5'h00, 8'h05, 2'b00);
        // Lock level shows in bit 4 and is not sticky
        syncSpecial <= 1'b1;
        repeat (3) @(posedge clk);
        rd(5'h00, 8'h10, 2'b00);
        syncSpecial <= 1'b0;
        repeat (3) @(posedge clk);
        rd(5'h00, 8'h00, 2'b00);
        $display("test_block done");
    endtask : test_block
    task automatic conclude;
        $display("compares %0d errTotal %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude
    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        test_regs();
        test_events();
        test_gating();
        test_block();
        conclude();
    end
    // Tests need about 200 cycles
    initial
    begin
        #(25 * 5000);
        errTotal++;
        conclude();
    end
endmodule : sbf_slip_flags_tb_top
